// file: hw/wdt_pkg.sv
// Constants shared by the key-locked watchdog timer.
// Assumes a 32-bit register port with byte addresses on an 8-bit bus.
package wdt_pkg;

  // Register byte offsets (set and clear aliases sit at +4 and +8)
  localparam logic [7:0] OFS_CONTROL       = 8'h00;
  localparam logic [7:0] OFS_CONTROL_SET   = 8'h04;
  localparam logic [7:0] OFS_CONTROL_CLR   = 8'h08;
  localparam logic [7:0] OFS_STATUS        = 8'h10;
  localparam logic [7:0] OFS_STATUS_SET    = 8'h14;
  localparam logic [7:0] OFS_STATUS_CLR    = 8'h18;
  localparam logic [7:0] OFS_THRESHOLD     = 8'h20;
  localparam logic [7:0] OFS_KEY           = 8'h30;

  // Control field positions
  localparam int CTL_IRQ_EN_BIT            = 0;
  localparam int CTL_DBG_SEL_BIT           = 1;
  // Status field positions
  localparam int STS_KEY_BIT               = 0;
  localparam int STS_UNLOCK_BIT            = 1;
  localparam int STS_EW_BIT                = 2;
  localparam int STS_RTH_BIT               = 3;
  localparam int STS_UPD_BIT               = 4;
  // Threshold field positions
  localparam int THR_EW_LSB                = 0;
  localparam int THR_RST_LSB               = 16;

  // Values after reset
  localparam logic       RST_IRQ_EN        = 1'b0;
  localparam logic       RST_DBG_SEL       = 1'b1;
  localparam logic [15:0] RST_EW_THRESHOLD = 16'h7fff;
  localparam logic [15:0] RST_RST_THRESHOLD = 16'hffff;
  localparam logic       RST_RUNNING       = 1'b1;

  // Key codes
  localparam logic [7:0] KEY_ATTENTION     = 8'ha5;
  localparam logic [7:0] KEY_WRITE         = 8'hf1;
  localparam logic [7:0] KEY_RESET         = 8'hcc;
  localparam logic [7:0] KEY_DISABLE       = 8'hdd;
  localparam logic [7:0] KEY_START         = 8'hee;
  localparam logic [7:0] KEY_LOCK          = 8'hff;

  // Oscillator cycles a threshold write takes to land
  localparam logic [2:0] UPD_LFO_CYCLES    = 3'h4;

  // Key interface state, one-hot
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b01,
    KEY_ARMED = 2'b10
  } key_state_t;

endpackage

// file: hw/watchdog_key_lock_timer.sv
// Watchdog timer with a lock-and-key register interface.
// Assumes one 40 MHz clock; the low-frequency oscillator arrives as a
// synchronous level input whose rising edges advance the counter.
// Register reads answer one cycle after the strobe.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

module watchdog_key_lock_timer
  import wdt_pkg::*;
#(
  parameter int CNT_W = 16                  // Counter and threshold width
) (
  input  wire logic              clk,                 // System clock
  input  wire logic              reset,               // Synchronous, active high
  input  wire logic              low_freq_oscillator, // Slow clock level, sampled
  input  wire logic              debug_halt,          // Core halted by debugger
  input  wire logic [7:0]        addr,                // Register byte address
  input  wire logic [31:0]       wr_data,             // Write data
  input  wire logic              wr_en,               // Write strobe
  input  wire logic              rd_en,               // Read strobe
  output logic      [31:0]       rd_data_ff,          // Read data, cycle after strobe
  output logic                   early_warning_irq_ff,// Warning interrupt
  output logic                   reset_request_ff     // System reset request
);

  // Counter and thresholds; the live thresholds only move when a
  // pending update lands, so compares never see a half-written pair
  logic [CNT_W-1:0] count_ff;               // Watchdog counter
  logic [CNT_W-1:0] nxt_count;              // Counter next value
  logic [CNT_W-1:0] early_warning_threshold_ff; // Active warning threshold
  logic [CNT_W-1:0] reset_threshold_ff;     // Active reset threshold
  logic [31:0]      thr_shadow_ff;          // Value waiting to land
  logic [2:0]       upd_cnt_ff;             // Oscillator edges seen while pending
  logic             threshold_update_pending_ff; // Update in flight
  // Control and status
  logic             early_warning_irq_enable_ff; // Warning interrupt enable
  logic             debug_halt_select_ff;   // Debug halt stops the counter
  logic             early_warning_flag_ff;  // Warning flag, set by hardware
  logic             nxt_ew_flag;            // Warning flag next value
  logic             running_ff;             // Cleared by disable
  logic             locked_ff;              // Disables are ignored once set
  logic             write_unlocked_flag_ff; // One write granted
  // Key interface state
  key_state_t       key_state_ff;           // Idle or awaiting a command
  key_state_t       nxt_key_state;          // Key state next value
  logic             lfo_prev_ff;            // Last oscillator sample

  // Address decode; set and clear aliases share the register behind them,
  // and each alias write needs a grant of its own
  wire sel_ctl      = (addr == OFS_CONTROL);
  wire sel_ctl_set  = (addr == OFS_CONTROL_SET);
  wire sel_ctl_clr  = (addr == OFS_CONTROL_CLR);
  wire sel_sts      = (addr == OFS_STATUS);
  wire sel_sts_set  = (addr == OFS_STATUS_SET);
  wire sel_sts_clr  = (addr == OFS_STATUS_CLR);
  wire sel_thr      = (addr == OFS_THRESHOLD);
  wire sel_key      = (addr == OFS_KEY);
  wire sel_ctl_any  = sel_ctl | sel_ctl_set | sel_ctl_clr;
  wire sel_sts_any  = sel_sts | sel_sts_set | sel_sts_clr;
  // A guarded write is any write that lands on a non-key register
  wire guarded_wr   = wr_en & (sel_ctl_any | sel_sts_any | sel_thr);
  wire wr_granted   = guarded_wr & write_unlocked_flag_ff;
  // Key decode, only meaningful while armed
  // A command byte acts only when it follows the attention code
  wire key_wr       = wr_en & sel_key;
  wire [7:0] key    = wr_data[7:0];
  wire armed        = (key_state_ff == KEY_ARMED);
  wire cmd_write    = key_wr & armed & (key == KEY_WRITE);
  wire cmd_reset    = key_wr & armed & (key == KEY_RESET);
  wire cmd_disable  = key_wr & armed & (key == KEY_DISABLE);
  wire cmd_start    = key_wr & armed & (key == KEY_START);
  wire cmd_lock     = key_wr & armed & (key == KEY_LOCK);

  // Oscillator edge and counting condition
  // The oscillator must stay high for at least one clk cycle to be seen;
  // comparing against last sample keeps one edge from counting twice
  wire lfo_rise     = low_freq_oscillator & ~lfo_prev_ff;
  wire halted       = debug_halt & debug_halt_select_ff;
  wire count_step   = lfo_rise & running_ff & ~halted;

  // Threshold comparisons against the live counter
  // The reset flag is a compare, not a latch: it drops as soon as the
  // counter is cleared or the threshold is raised
  wire ew_match     = (count_ff == early_warning_threshold_ff);
  wire reset_threshold_reached = (count_ff >= reset_threshold_ff);

  // Status word as read by software
  // Reserved bits read as zero
  wire [31:0] status_word = {27'h0,
                             threshold_update_pending_ff,
                             reset_threshold_reached,
                             early_warning_flag_ff,
                             write_unlocked_flag_ff,
                             armed};
  // Control word: debug select above the interrupt enable
  wire [31:0] control_word = {30'h0, debug_halt_select_ff,
                              early_warning_irq_enable_ff};
  // Threshold word: reset field on top, warning field below
  wire [31:0] threshold_word = {reset_threshold_ff, early_warning_threshold_ff};

  // Read mux; unmapped and key addresses read zero
  // Reading never changes state, so reads are safe at any time
  wire [31:0] rd_mux = sel_ctl_any ? control_word   :
                       sel_sts_any ? status_word    :
                       sel_thr     ? threshold_word : 32'h0;

  // Key state next value: attention arms, and any key write while armed
  // uses the armed state up, so a stray byte cannot leave it open
  always_comb begin
    nxt_key_state = key_state_ff;
    case (key_state_ff)
      KEY_IDLE: begin
        // Only the attention code opens a sequence; other bytes are ignored
        if (key_wr && key == KEY_ATTENTION) begin
          nxt_key_state = KEY_ARMED;
        end
      end
      KEY_ARMED: begin
        // Valid or not, the armed state is used up by one key write
        if (key_wr) begin
          nxt_key_state = KEY_IDLE;
        end
      end
      default: begin
        // Illegal code: fall back to awaiting attention
        nxt_key_state = KEY_IDLE;
      end
    endcase
  end

  // Counter next value
  // A reset command wins over a count step in the same cycle
  always_comb begin
    nxt_count = count_ff;
    if (cmd_reset) begin
      nxt_count = '0;
    end else if (count_step) begin
      nxt_count = count_ff + 1'b1;
    end
  end

  // Warning flag: hardware set wins over a software clear in the same cycle
  // Software may also set the flag to raise the interrupt by hand
  always_comb begin
    nxt_ew_flag = early_warning_flag_ff;
    if (wr_granted && sel_sts) begin
      nxt_ew_flag = wr_data[STS_EW_BIT];
    end else if (wr_granted && sel_sts_set && wr_data[STS_EW_BIT]) begin
      nxt_ew_flag = 1'b1;
    end else if (wr_granted && sel_sts_clr && wr_data[STS_EW_BIT]) begin
      nxt_ew_flag = 1'b0;
    end
    if (ew_match) begin
      nxt_ew_flag = 1'b1;
    end
  end

  // Key state register
  // System reset returns it to awaiting the attention code
  always_ff @(posedge clk) begin
    if (reset) begin
      key_state_ff <= KEY_IDLE;
    end else begin
      key_state_ff <= nxt_key_state;
    end
  end

  // Single-write grant: set by the write command, spent by one write
  // A threshold write dropped while an update is pending still spends it
  always_ff @(posedge clk) begin
    if (reset) begin
      write_unlocked_flag_ff <= 1'b0;
    end else if (cmd_write) begin
      write_unlocked_flag_ff <= 1'b1;
    end else if (wr_granted) begin
      write_unlocked_flag_ff <= 1'b0;
    end
  end

  // Run and lock state
  // Lock only blocks disable; start still works, and only a system
  // reset clears the lock
  always_ff @(posedge clk) begin
    if (reset) begin
      running_ff <= RST_RUNNING;
      locked_ff  <= 1'b0;
    end else begin
      if (cmd_lock) begin
        locked_ff <= 1'b1;
      end
      if (cmd_disable && !locked_ff) begin
        running_ff <= 1'b0;
      end else if (cmd_start) begin
        running_ff <= 1'b1;
      end
    end
  end

  // Counter and oscillator sample
  // The counter wraps at the top of its range
  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff    <= '0;
      lfo_prev_ff <= 1'b0;
    end else begin
      count_ff    <= nxt_count;
      lfo_prev_ff <= low_freq_oscillator;
    end
  end

  // Control register; writes only through a granted access
  // Plain, set and clear forms; each one spends the grant
  always_ff @(posedge clk) begin
    if (reset) begin
      early_warning_irq_enable_ff <= RST_IRQ_EN;
      debug_halt_select_ff        <= RST_DBG_SEL;
    end else if (wr_granted && sel_ctl) begin
      early_warning_irq_enable_ff <= wr_data[CTL_IRQ_EN_BIT];
      debug_halt_select_ff        <= wr_data[CTL_DBG_SEL_BIT];
    end else if (wr_granted && sel_ctl_set) begin
      early_warning_irq_enable_ff <= early_warning_irq_enable_ff | wr_data[CTL_IRQ_EN_BIT];
      debug_halt_select_ff        <= debug_halt_select_ff | wr_data[CTL_DBG_SEL_BIT];
    end else if (wr_granted && sel_ctl_clr) begin
      early_warning_irq_enable_ff <= early_warning_irq_enable_ff & ~wr_data[CTL_IRQ_EN_BIT];
      debug_halt_select_ff        <= debug_halt_select_ff & ~wr_data[CTL_DBG_SEL_BIT];
    end
  end

  // Warning flag register
  always_ff @(posedge clk) begin
    if (reset) begin
      early_warning_flag_ff <= 1'b0;
    end else begin
      early_warning_flag_ff <= nxt_ew_flag;
    end
  end

  // Threshold update: captured now, lands after oscillator edges.
  // Both fields land together, so a pair written in one access is atomic.
  // A write during a pending update is dropped so the landing value
  // stays the one software saw accepted.
  always_ff @(posedge clk) begin
    if (reset) begin
      thr_shadow_ff               <= {RST_RST_THRESHOLD, RST_EW_THRESHOLD};
      upd_cnt_ff                  <= 3'h0;
      threshold_update_pending_ff <= 1'b0;
      early_warning_threshold_ff  <= RST_EW_THRESHOLD;
      reset_threshold_ff          <= RST_RST_THRESHOLD;
    end else if (wr_granted && sel_thr && !threshold_update_pending_ff) begin
      thr_shadow_ff               <= wr_data;
      upd_cnt_ff                  <= 3'h0;
      threshold_update_pending_ff <= 1'b1;
    end else if (threshold_update_pending_ff && lfo_rise) begin
      if (upd_cnt_ff == UPD_LFO_CYCLES - 3'h1) begin
        early_warning_threshold_ff  <= thr_shadow_ff[THR_EW_LSB +: CNT_W];
        reset_threshold_ff          <= thr_shadow_ff[THR_RST_LSB +: CNT_W];
        threshold_update_pending_ff <= 1'b0;
        upd_cnt_ff                  <= 3'h0;
      end else begin
        upd_cnt_ff <= upd_cnt_ff + 3'h1;
      end
    end
  end

  // Outputs, all registered
  // Both use next values so they line up with the flag and counter
  // registers instead of trailing them by a cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_ff           <= 32'h0;
      early_warning_irq_ff <= 1'b0;
      reset_request_ff     <= 1'b0;
    end else begin
      rd_data_ff           <= rd_en ? rd_mux : 32'h0;
      early_warning_irq_ff <= nxt_ew_flag & early_warning_irq_enable_ff;
      reset_request_ff     <= (nxt_count >= reset_threshold_ff);
    end
  end

endmodule // watchdog_key_lock_timer

// file: bench/wdt_checker_assertions.sv
// Concurrent checks on the key-locked watchdog's register port and outputs.
// Sees only the top-level ports; bound to every instance of the timer.
`timescale 1ns/1ps
module wdt_checker
  import wdt_pkg::*;
#(
  parameter int CNT_W = 16  // Mirrors the design, unused here
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        low_freq_oscillator,
  input wire logic        debug_halt,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data_ff,
  input wire logic        early_warning_irq_ff,
  input wire logic        reset_request_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Key and unmapped places read as zero; aliases left out, their reads are open
  wire zero_rd = !(addr inside {OFS_CONTROL, OFS_CONTROL_SET, OFS_CONTROL_CLR, OFS_STATUS,
                                OFS_STATUS_SET, OFS_STATUS_CLR, OFS_THRESHOLD});
  wire sts_rd  = rd_en && addr == OFS_STATUS;  // Status read
  wire key_wr  = wr_en && addr == OFS_KEY;     // Key write
  wire bad_key = !(wr_data[7:0] inside {KEY_ATTENTION, KEY_WRITE, KEY_RESET, KEY_DISABLE, KEY_START, KEY_LOCK});
  // Key steps two cycles apart, with no write in the cycle between
  sequence s_idle; key_wr && bad_key; endsequence
  sequence s_arm; s_idle ##1 !wr_en ##1 key_wr && wr_data[7:0] == KEY_ATTENTION; endsequence
  sequence s_grant; s_arm ##1 !wr_en ##1 key_wr && wr_data[7:0] == KEY_WRITE; endsequence
  property p_rd_quiet; !rd_en |=> rd_data_ff == 32'h0; endproperty
  property p_zero_rd; rd_en && zero_rd |=> rd_data_ff == 32'h0; endproperty
  property p_sts_rsvd; sts_rd |=> rd_data_ff[31:5] == 27'h0; endproperty
  property p_rth_mirror; sts_rd |=> rd_data_ff[STS_RTH_BIT] == $past(reset_request_ff); endproperty
  property p_irq_flag; sts_rd && early_warning_irq_ff |=> rd_data_ff[STS_EW_BIT]; endproperty
  property p_irq_off; (rd_en && addr == OFS_CONTROL) ##1 !rd_data_ff[CTL_IRQ_EN_BIT] |-> !early_warning_irq_ff;
  endproperty
  property p_relock; (wr_en && !zero_rd) ##1 !wr_en ##1 sts_rd |=> !rd_data_ff[STS_UNLOCK_BIT]; endproperty
  property p_invalid; s_idle ##1 !wr_en ##1 sts_rd |=> !rd_data_ff[STS_KEY_BIT]; endproperty
  property p_arm; s_arm ##1 !wr_en ##1 sts_rd |=> rd_data_ff[STS_KEY_BIT]; endproperty
  property p_grant; s_grant ##1 !wr_en ##1 sts_rd |=> rd_data_ff[1:0] == 2'b10; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not zero");
  a_zero_rd: assert property (p_zero_rd) else $error("key or unmapped read not zero");
  a_sts_rsvd: assert property (p_sts_rsvd) else $error("status spare bits set");
  a_rth_mirror: assert property (p_rth_mirror) else $error("reset flag differs from request");
  a_irq_flag: assert property (p_irq_flag) else $error("irq without warning flag");
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  a_relock: assert property (p_relock) else $error("still unlocked after write");
  a_invalid: assert property (p_invalid) else $error("invalid key left armed");
  a_arm: assert property (p_arm) else $error("attention not armed");
  a_grant: assert property (p_grant) else $error("write grant not shown");
endmodule // wdt_checker

bind watchdog_key_lock_timer wdt_checker #(.CNT_W(CNT_W)) i_chk (.clk(clk), .reset(reset),
  .low_freq_oscillator(low_freq_oscillator), .debug_halt(debug_halt), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data_ff(rd_data_ff), .early_warning_irq_ff(early_warning_irq_ff),
  .reset_request_ff(reset_request_ff));

// file: bench/tb.sv
// Self-checking bench for the key-locked watchdog timer.
// Drives the register port and oscillator level directly; no far-side model.
`timescale 1ns/1ps
module tb;
  import wdt_pkg::*;
  logic        clk, reset, osc, dbg, wr_en, rd_en;  // Stimulus
  logic [7:0]  addr;                                // Register address
  logic [31:0] wr_data, rd_data_ff;                 // Bus data
  logic        irq, req;                            // Outputs watched
  int          error_cnt, n_checks;                 // Tallies
  watchdog_key_lock_timer i_dut (.clk(clk), .reset(reset), .low_freq_oscillator(osc), .debug_halt(dbg),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_ff(rd_data_ff),
    .early_warning_irq_ff(irq), .reset_request_ff(req));
  // Compare and tally
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, act);
      error_cnt++;
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // Read; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(nm, exp, rd_data_ff);
  endtask
  task automatic key(input logic [7:0] c);
    wr(OFS_KEY, {24'h0, c});
  endtask
  task automatic cmd(input logic [7:0] c);
    key(KEY_ATTENTION);
    key(c);
  endtask
  // Slow oscillator edges, then settle so synchronised edges land
  task automatic lfo(input int n);
    repeat (n) begin
      @(posedge clk);
      osc <= 1'b1;
      repeat (2) @(posedge clk);
      osc <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Poll the pending flag, one oscillator edge per try; bounded
  task automatic poll_upd;
    logic busy;
    busy = 1'b1;
    for (int i = 0; i < 8 && busy; i++) begin
      lfo(1);
      @(posedge clk);
      addr  <= OFS_STATUS;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 busy = rd_data_ff[STS_UPD_BIT];
    end
    chk("pending", 32'h0, {31'h0, busy});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    $display("[ERR] run limit expected end seen none");
    error_cnt++;
    finish_test;
  end
  initial begin
    {reset, osc, dbg, wr_en, rd_en, addr, wr_data} = {1'b1, 44'h0};
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CONTROL, "control", 32'h2);
    rd(OFS_THRESHOLD, "threshold", {RST_RST_THRESHOLD, RST_EW_THRESHOLD});
    rd(8'h3c, "unmapped", 32'h0);
    wr(OFS_THRESHOLD, 32'h0);
    wr(OFS_CONTROL, 32'h1);
    rd(OFS_THRESHOLD, "threshold", {RST_RST_THRESHOLD, RST_EW_THRESHOLD});
    rd(OFS_CONTROL, "control", 32'h2);
    key(8'h12);
    rd(OFS_STATUS, "status", 32'h0);
    key(8'h12);
    key(KEY_ATTENTION);
    rd(OFS_STATUS, "status", 32'h1);
    key(KEY_ATTENTION);
    rd(OFS_STATUS, "status", 32'h0);
    key(KEY_WRITE);
    rd(OFS_STATUS, "status", 32'h0);
    $display("test key states done");
    key(8'h12);
    cmd(KEY_WRITE);
    rd(OFS_STATUS, "status", 32'h2);
    wr(OFS_THRESHOLD, 32'h000a_0006);
    rd(OFS_STATUS, "status", 32'h10);
    rd(OFS_THRESHOLD, "threshold", {RST_RST_THRESHOLD, RST_EW_THRESHOLD});
    lfo(UPD_LFO_CYCLES);
    rd(OFS_STATUS, "status", 32'h0);
    rd(OFS_THRESHOLD, "threshold", 32'h000a_0006);
    wr(OFS_THRESHOLD, 32'h0);
    rd(OFS_THRESHOLD, "threshold", 32'h000a_0006);
    $display("test threshold write done");
    cmd(KEY_RESET);
    cmd(KEY_WRITE);
    wr(OFS_CONTROL, 32'h1);
    lfo(5);
    chk("irq", 32'h0, {31'h0, irq});
    lfo(1);
    chk("irq", 32'h1, {31'h0, irq});
    rd(OFS_STATUS, "status", 32'h4);
    lfo(3);
    chk("req", 32'h0, {31'h0, req});
    lfo(1);
    chk("req", 32'h1, {31'h0, req});
    cmd(KEY_RESET);
    rd(OFS_STATUS, "status", 32'h4);
    cmd(KEY_WRITE);
    wr(OFS_STATUS_CLR, 32'h4);
    lfo(0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test thresholds done");
    cmd(KEY_DISABLE);
    lfo(10);
    chk("req", 32'h0, {31'h0, req});
    cmd(KEY_START);
    lfo(10);
    chk("req", 32'h1, {31'h0, req});
    cmd(KEY_LOCK);
    cmd(KEY_RESET);
    lfo(0);
    chk("req", 32'h0, {31'h0, req});
    cmd(KEY_DISABLE);
    lfo(10);
    chk("req", 32'h1, {31'h0, req});
    cmd(KEY_RESET);
    cmd(KEY_WRITE);
    wr(OFS_CONTROL, 32'h2);
    rd(OFS_CONTROL, "control", 32'h2);
    @(posedge clk) dbg <= 1'b1;
    lfo(10);
    chk("req", 32'h0, {31'h0, req});
    cmd(KEY_WRITE);
    wr(OFS_CONTROL, 32'h0);
    lfo(10);
    chk("req", 32'h1, {31'h0, req});
    $display("test run control done");
    // Mid-run system reset must drop the lock
    @(posedge clk);
    reset <= 1'b1;
    dbg   <= 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_CONTROL, "control", 32'h2);
    cmd(KEY_DISABLE);
    cmd(KEY_WRITE);
    wr(OFS_THRESHOLD, 32'hffff_0003);
    cmd(KEY_WRITE);
    wr(OFS_THRESHOLD, 32'h0004_0004);
    rd(OFS_STATUS, "status", 32'h10);
    poll_upd;
    rd(OFS_THRESHOLD, "threshold", 32'hffff_0003);
    cmd(KEY_WRITE);
    wr(OFS_THRESHOLD, 32'h0004_0003);
    poll_upd;
    rd(OFS_THRESHOLD, "threshold", 32'h0004_0003);
    chk("req", 32'h0, {31'h0, req});
    cmd(KEY_START);
    lfo(4);
    chk("req", 32'h1, {31'h0, req});
    chk("irq", 32'h0, {31'h0, irq});
    rd(OFS_STATUS, "status", 32'hc);
    cmd(KEY_WRITE);
    wr(OFS_CONTROL_SET, 32'h1);
    rd(OFS_CONTROL_CLR, "control", 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    cmd(KEY_WRITE);
    wr(OFS_CONTROL_CLR, 32'h2);
    rd(OFS_CONTROL, "control", 32'h1);
    cmd(KEY_WRITE);
    wr(OFS_STATUS, 32'h0);
    rd(OFS_STATUS, "status", 32'h8);
    chk("irq", 32'h0, {31'h0, irq});
    cmd(KEY_WRITE);
    wr(OFS_STATUS_SET, 32'h4);
    rd(OFS_STATUS, "status", 32'hc);
    chk("irq", 32'h1, {31'h0, irq});
    $display("test reset and aliases done");
    finish_test;
  end
endmodule // tb
